// >>> interval_timer_top.sv
// Interval timer block: APB registers, two timer channels, event edge
// detect and registered output pins.
// Assumes all inputs are synchronous to pclk; irq pulses go to an outside
// interrupt controller that applies its own masks.
//
// Behaviour
// (R1) Channel counts only when its mode field holds interval code 000.
// (R2) Enable: counter goes FFFF to 0000 on next count, output 0 inverts.
// (R3) At count start the period register is copied into its shadow.
// (R4) Counter equal to period shadow: clear, invert output 0, pulse irq.
// (R5) Interval equals period value plus one count clocks.
// (R6) Aux compares load shadows; a match pulses its irq, inverts its output.
// (R7) Aux compare writes reach shadows while running, counter keeps going.
// (R8) Period 0000: counter stays 0, irq and toggle every count.
// (R9) Period FFFF: full count then clear, with no overflow event or flag.
// (R10) Period writes apply at once; overshoot wraps through FFFF.
// (R11) Software stops the counter before lowering the period.
// (R12) Aux equal to period: irq with the period irq, 50% output.
// (R13) Aux below period: one irq per cycle, short first pulse then 50%.
// (R14) Aux above period: no match, no irq, output unchanged.
// (R15) Software sets unused aux compares to FFFF and masks their irq.
// (R16) Event clocking: first valid edge starts count, later edges advance it.
// (R17) Event clocking with compares at 0001 toggles outputs every two counts.
// (R18) Software enables event clocking only when outputs are in use.
// (R19) Software uses edge select only with equal period and aux values.
// (R20) Counter readback returns the live 16-bit counter; the code returns it one cycle old, and zero while the channel is stopped.
// (R21) Capture control and option registers have no effect in this mode.
// (R22) Outputs idle at polarity level, take opposite level once counting.
// (R23) Two channels; only channel 0 has aux outputs and event clock.
`timescale 1ns/1ns
module interval_timer_top (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // External event
   input wire logic external_event_input,
   // Channel 0 pins and events
   output logic ch0_timer_out_0,
   output logic [2:0] ch0_timer_out_aux,
   output logic ch0_compare0_match_irq,
   output logic [2:0] ch0_compare_aux_irq,
   // Channel 1 pins and events
   output logic ch1_timer_out_0,
   output logic ch1_compare0_match_irq,
   output logic [2:0] ch1_compare_aux_irq
);
   // Register storage, indexed by channel except ioc2 (channel 0 only)
   logic [1:0][8:0] ctl, next_ctl;
   logic [1:0][7:0] ioc0, next_ioc0;
   logic [1:0][3:0][15:0] ccr, next_ccr;
   logic [1:0][7:0] ioc1, next_ioc1;
   logic [1:0][7:0] opt0, next_opt0;
   logic [1:0] ioc2, next_ioc2;
   // Bus
   logic [31:0] next_prdata;
   logic next_pready;
   logic next_pslverr;
   logic setup;
   logic wr_en;
   logic ch;
   logic [5:0] off;
   logic bad;
   // Event and channel links
   logic ev_q;
   logic ev_edge;
   logic tick0;
   itm_pkg::ch_cfg_t cfg0, cfg1;
   itm_pkg::ch_stat_t stat0, stat1;
   logic [1:0][15:0] rdback;
   logic [4:0] pins, next_pins;

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   assign ch = paddr[itm_pkg::CH_SEL_BIT];
   assign off = paddr[5:0];
   assign setup = psel && !penable;
   assign wr_en = psel && penable && pready && pwrite && !pslverr;

   // Unmapped: out of range, misaligned, or channel 1 edge select
   always_comb begin
      bad = 1'b0;
      case (off)
         itm_pkg::OFF_CTL, itm_pkg::OFF_IOC0, itm_pkg::OFF_COMPARE_SHADOW_0,
         itm_pkg::OFF_CCR1, itm_pkg::OFF_CCR2, itm_pkg::OFF_CCR3,
         itm_pkg::OFF_CNT, itm_pkg::OFF_IOC1, itm_pkg::OFF_OPT0: begin
            bad = 1'b0;
         end
         itm_pkg::OFF_IOC2: begin
            bad = ch;
         end
         default: begin
            bad = 1'b1;
         end
      endcase
      if (paddr[itm_pkg::OUT_RANGE_BIT]) begin
         bad = 1'b1;
      end
   end

   // ----------------------------------------
   // Counter readback
   // ----------------------------------------
   // A stopped channel reads zero although its counter rests at FFFF
   assign rdback[0] = ctl[0][itm_pkg::CTL_CE_BIT] ? stat0.cnt : itm_pkg::READ_STOPPED; // R20
   assign rdback[1] = ctl[1][itm_pkg::CTL_CE_BIT] ? stat1.cnt : itm_pkg::READ_STOPPED; // R20

   // ----------------------------------------
   // APB answer
   // ----------------------------------------
   // Read data is sampled in the setup cycle so that prdata leaves a
   // flip-flop; the price is a counter value one cycle old.
   always_comb begin
      next_prdata = prdata;
      next_pready = setup;
      next_pslverr = setup && bad;
      if (setup) begin
         next_prdata = 32'h0000_0000;
         if (!bad && !pwrite) begin
            case (off)
               itm_pkg::OFF_CTL: next_prdata[8:0] = ctl[ch];
               itm_pkg::OFF_IOC0: next_prdata[7:0] = ioc0[ch];
               itm_pkg::OFF_COMPARE_SHADOW_0: next_prdata[15:0] = ccr[ch][0];
               itm_pkg::OFF_CCR1: next_prdata[15:0] = ccr[ch][1];
               itm_pkg::OFF_CCR2: next_prdata[15:0] = ccr[ch][2];
               itm_pkg::OFF_CCR3: next_prdata[15:0] = ccr[ch][3];
               itm_pkg::OFF_CNT: next_prdata[15:0] = rdback[ch]; // R20
               itm_pkg::OFF_IOC1: next_prdata[7:0] = ioc1[ch];
               itm_pkg::OFF_OPT0: next_prdata[7:0] = opt0[ch]; // R9
               itm_pkg::OFF_IOC2: next_prdata[1:0] = ioc2;
               default: next_prdata = 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   // ----------------------------------------
   // Register writes
   // ----------------------------------------
   // The overflow bit never sets in this mode, so it is held at zero
   always_comb begin
      next_ctl = ctl;
      next_ioc0 = ioc0;
      next_ccr = ccr;
      next_ioc1 = ioc1;
      next_opt0 = opt0;
      next_ioc2 = ioc2;
      if (wr_en) begin
         case (off)
            itm_pkg::OFF_CTL: next_ctl[ch] = pwdata[8:0];
            itm_pkg::OFF_IOC0: next_ioc0[ch] = pwdata[7:0];
            itm_pkg::OFF_COMPARE_SHADOW_0: next_ccr[ch][0] = pwdata[15:0]; // R10
            itm_pkg::OFF_CCR1: next_ccr[ch][1] = pwdata[15:0]; // R7
            itm_pkg::OFF_CCR2: next_ccr[ch][2] = pwdata[15:0]; // R7
            itm_pkg::OFF_CCR3: next_ccr[ch][3] = pwdata[15:0]; // R7
            itm_pkg::OFF_IOC1: next_ioc1[ch] = pwdata[7:0]; // R21
            itm_pkg::OFF_OPT0: next_opt0[ch] = pwdata[7:0]; // R21
            itm_pkg::OFF_IOC2: next_ioc2 = pwdata[1:0];
            default: next_ctl = ctl;
         endcase
      end
      next_opt0[0][itm_pkg::OPT0_OVF_BIT] = 1'b0; // R9
      next_opt0[1][itm_pkg::OPT0_OVF_BIT] = 1'b0; // R9
      next_ctl[1][itm_pkg::CTL_EEE_BIT] = 1'b0; // R23
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl <= {2{itm_pkg::CTL_RST}};
         ioc0 <= {2{itm_pkg::BYTE_RST}};
         ccr <= {8{itm_pkg::CCR_RST}};
         ioc1 <= {2{itm_pkg::BYTE_RST}};
         opt0 <= {2{itm_pkg::BYTE_RST}};
         ioc2 <= itm_pkg::EDGE_NONE;
      end else begin
         ctl <= next_ctl;
         ioc0 <= next_ioc0;
         ccr <= next_ccr;
         ioc1 <= next_ioc1;
         opt0 <= next_opt0;
         ioc2 <= next_ioc2;
      end
   end

   // ----------------------------------------
   // Event edge detect and count clock
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ev_q <= 1'b0;
      end else begin
         ev_q <= external_event_input;
      end
   end

   always_comb begin
      case (ioc2)
         itm_pkg::EDGE_RISE: ev_edge = external_event_input && !ev_q;
         itm_pkg::EDGE_FALL: ev_edge = !external_event_input && ev_q;
         itm_pkg::EDGE_BOTH: ev_edge = external_event_input != ev_q;
         default: ev_edge = 1'b0;
      endcase
   end

   // Internal count clock is every pclk cycle
   assign tick0 = ctl[0][itm_pkg::CTL_EEE_BIT] ? ev_edge : 1'b1; // R16 R23

   // ----------------------------------------
   // Channels
   // ----------------------------------------
   assign cfg0.enable = ctl[0][itm_pkg::CTL_CE_BIT];
   assign cfg0.mode = ctl[0][itm_pkg::CTL_MODE_LSB +: 3];
   assign cfg0.period = ccr[0][0];
   assign cfg0.aux = {ccr[0][3], ccr[0][2], ccr[0][1]};
   assign cfg1.enable = ctl[1][itm_pkg::CTL_CE_BIT];
   assign cfg1.mode = ctl[1][itm_pkg::CTL_MODE_LSB +: 3];
   assign cfg1.period = ccr[1][0];
   assign cfg1.aux = {ccr[1][3], ccr[1][2], ccr[1][1]};

   itm_channel u_ch0 (
      .pclk(pclk),
      .presetn(presetn),
      .cfg(cfg0),
      .tick(tick0),
      .stat(stat0)
   );

   itm_channel u_ch1 (
      .pclk(pclk),
      .presetn(presetn),
      .cfg(cfg1),
      .tick(1'b1),
      .stat(stat1)
   );

   // ----------------------------------------
   // Output pins
   // ----------------------------------------
   // Level is polarity when disabled; toggles only show while enabled.
   always_comb begin
      for (int a = 0; a < 4; a++) begin
         next_pins[a] = ioc0[0][itm_pkg::IOC0_POL_LSB + a] ^
            (ioc0[0][itm_pkg::IOC0_OE_LSB + a] & stat0.tog[a]); // R22
      end
      next_pins[4] = ioc0[1][itm_pkg::IOC0_POL_LSB] ^
         (ioc0[1][itm_pkg::IOC0_OE_LSB] & stat1.tog[0]); // R22 R23
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pins <= 5'h00;
      end else begin
         pins <= next_pins;
      end
   end

   assign ch0_timer_out_0 = pins[0];
   assign ch0_timer_out_aux = pins[3:1];
   assign ch1_timer_out_0 = pins[4];
   assign ch0_compare0_match_irq = stat0.irq[0];
   assign ch0_compare_aux_irq = stat0.irq[3:1];
   assign ch1_compare0_match_irq = stat1.irq[0];
   assign ch1_compare_aux_irq = stat1.irq[3:1];

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_READBACK: assert property ((setup && !pwrite && !bad && off == itm_pkg::OFF_CNT) |=> // R20
      (pready && prdata[15:0] == $past(rdback[ch]) && prdata[31:16] == 16'h0000))
      else $error("counter readback mismatch");
   AST_POL_IDLE: assert property (!ctl[0][itm_pkg::CTL_CE_BIT] ##1 !ctl[0][itm_pkg::CTL_CE_BIT] |=> // R22
      ch0_timer_out_0 == $past(ioc0[0][itm_pkg::IOC0_POL_LSB]))
      else $error("stopped output not at polarity level");
   AST_EVT_TICK: assert property ((ctl[0][itm_pkg::CTL_EEE_BIT] && !ev_edge) |-> !tick0) // R16
      else $error("event clock ticked without an edge");
   AST_CCR_WRITE: assert property ((wr_en && off == itm_pkg::OFF_CCR1) |=> // R7
      ccr[$past(ch)][1] == $past(pwdata[15:0]))
      else $error("aux compare write lost");
   AST_NO_OVF: assert property (opt0[0][itm_pkg::OPT0_OVF_BIT] == 1'b0 && opt0[1][itm_pkg::OPT0_OVF_BIT] == 1'b0) // R9
      else $error("overflow flag set in interval mode");

   COV_APB_WRITE: cover property (wr_en && off == itm_pkg::OFF_CTL);
   COV_EVT_START: cover property (ctl[0][itm_pkg::CTL_EEE_BIT] && ev_edge && ch0_compare0_match_irq);
endmodule

// >>> itm_pkg.sv
// Constants, register map and carrier types for the interval timer block.
// Assumes an APB slave with an 8-bit byte address and 32-bit data.
package itm_pkg;

   // ----------------------------------------
   // Mode and counter values
   // ----------------------------------------
   localparam logic [2:0] MODE_INTERVAL = 3'h0;
   localparam logic [15:0] CNT_IDLE = 16'hFFFF;
   localparam logic [15:0] CNT_ZERO = 16'h0000;
   localparam logic [15:0] CNT_ONE = 16'h0001;
   localparam logic [15:0] READ_STOPPED = 16'h0000;

   // ----------------------------------------
   // Register offsets inside one channel window
   // ----------------------------------------
   localparam logic [5:0] OFF_CTL = 6'h00;
   localparam logic [5:0] OFF_IOC0 = 6'h04;
   localparam logic [5:0] OFF_COMPARE_SHADOW_0 = 6'h08;
   localparam logic [5:0] OFF_CCR1 = 6'h0C;
   localparam logic [5:0] OFF_CCR2 = 6'h10;
   localparam logic [5:0] OFF_CCR3 = 6'h14;
   localparam logic [5:0] OFF_CNT = 6'h18;
   localparam logic [5:0] OFF_IOC1 = 6'h1C;
   localparam logic [5:0] OFF_OPT0 = 6'h20;
   localparam logic [5:0] OFF_IOC2 = 6'h24;
   localparam int CH_SEL_BIT = 6;
   localparam int OUT_RANGE_BIT = 7;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int CTL_CE_BIT = 0;
   localparam int CTL_MODE_LSB = 4;
   localparam int CTL_EEE_BIT = 8;
   localparam int IOC0_OE_LSB = 0;
   localparam int IOC0_POL_LSB = 4;
   localparam int OPT0_OVF_BIT = 0;

   // ----------------------------------------
   // Reset values and edge codes
   // ----------------------------------------
   localparam logic [15:0] CCR_RST = 16'h0000;
   localparam logic [8:0] CTL_RST = 9'h000;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [1:0] EDGE_NONE = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_ARMED = 3'b010,
      ST_RUN = 3'b100
   } ch_state_t;

   typedef struct packed {
      logic enable;
      logic [2:0] mode;
      logic [15:0] period;
      logic [2:0][15:0] aux;
   } ch_cfg_t;

   typedef struct packed {
      logic [15:0] cnt;
      logic [3:0] irq;
      logic [3:0] tog;
   } ch_stat_t;

endpackage

// >>> itm_channel.sv
// One timer channel: 16-bit up-counter, period compare and three aux compares.
// Assumes a one-cycle tick from the parent; config is static between writes.
`timescale 1ns/1ns
module itm_channel (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control
   input itm_pkg::ch_cfg_t cfg,
   input wire logic tick,
   // Status
   output itm_pkg::ch_stat_t stat
);
   itm_pkg::ch_state_t st, next_st;
   logic [15:0] cnt, next_cnt;
   logic [15:0] sh0, next_sh0;
   logic [2:0][15:0] sh, next_sh;
   logic [3:0] irq, next_irq;
   logic [3:0] tog, next_tog;
   logic active;

   assign active = cfg.enable && (cfg.mode == itm_pkg::MODE_INTERVAL); // R1 R21

   // ----------------------------------------
   // Counter, shadows and toggles
   // ----------------------------------------
   // Shadows track the compare registers every cycle while running, so a
   // write lands at once and the counter never stops.
   always_comb begin
      next_st = st;
      next_cnt = cnt;
      next_sh0 = sh0;
      next_sh = sh;
      next_irq = 4'h0;
      next_tog = tog;
      if (!active) begin
         next_st = itm_pkg::ST_IDLE;
         next_cnt = itm_pkg::CNT_IDLE;
         next_tog = 4'h0;
      end else begin
         case (st)
            itm_pkg::ST_IDLE: begin
               next_st = itm_pkg::ST_ARMED;
            end
            itm_pkg::ST_ARMED: begin
               if (tick) begin
                  next_st = itm_pkg::ST_RUN;
                  next_cnt = itm_pkg::CNT_ZERO; // R2 R16
                  next_tog = 4'hF; // R2 R22
                  next_sh0 = cfg.period; // R3
                  next_sh = cfg.aux; // R6
               end
            end
            itm_pkg::ST_RUN: begin
               next_sh0 = cfg.period; // R10
               next_sh = cfg.aux; // R7
               if (tick) begin
                  // Wrap from FFFF to 0 is silent: no overflow here
                  next_cnt = cnt + itm_pkg::CNT_ONE; // R5 R9 R10
                  if (cnt == sh0) begin
                     next_cnt = itm_pkg::CNT_ZERO; // R4 R8
                     next_irq[0] = 1'b1;
                     next_tog[0] = ~tog[0];
                  end
                  for (int b = 0; b < 3; b++) begin
                     if (cnt == sh[b]) begin
                        next_irq[b + 1] = 1'b1; // R6 R12 R13 R14 R17
                        next_tog[b + 1] = ~tog[b + 1];
                     end
                  end
               end
            end
            default: begin
               next_st = itm_pkg::ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= itm_pkg::ST_IDLE;
         cnt <= itm_pkg::CNT_IDLE;
         sh0 <= itm_pkg::CCR_RST;
         sh <= '0;
         irq <= 4'h0;
         tog <= 4'h0;
      end else begin
         st <= next_st;
         cnt <= next_cnt;
         sh0 <= next_sh0;
         sh <= next_sh;
         irq <= next_irq;
         tog <= next_tog;
      end
   end

   assign stat.cnt = cnt;
   assign stat.irq = irq;
   assign stat.tog = tog;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_MODE_GATE: assert property (!active |=> st == itm_pkg::ST_IDLE) // R1
      else $error("channel not idle outside interval mode");
   AST_START: assert property ((st == itm_pkg::ST_ARMED && active && tick) |=> // R2
      (cnt == itm_pkg::CNT_ZERO && tog == 4'hF && st == itm_pkg::ST_RUN))
      else $error("start step wrong");
   AST_SHADOW0: assert property ((st == itm_pkg::ST_ARMED && active && tick) |=> // R3
      sh0 == $past(cfg.period))
      else $error("period shadow not loaded at start");
   AST_MATCH0: assert property ((st == itm_pkg::ST_RUN && active && tick && cnt == sh0) |=> // R4
      (cnt == itm_pkg::CNT_ZERO && irq[0] && tog[0] != $past(tog[0])))
      else $error("period match step wrong");
   AST_ADVANCE: assert property ((st == itm_pkg::ST_RUN && active && tick && cnt != sh0) |=> // R5
      (cnt == $past(cnt) + itm_pkg::CNT_ONE && !irq[0]))
      else $error("counter did not advance by one");
   AST_HOLD: assert property ((st == itm_pkg::ST_RUN && active && !tick) |=> // R16
      (cnt == $past(cnt) && irq == 4'h0))
      else $error("counter moved without a tick");
   AST_FOLLOW: assert property ((st == itm_pkg::ST_RUN && active) |=> // R7
      (sh == $past(cfg.aux) && sh0 == $past(cfg.period)))
      else $error("shadow did not follow register");
   AST_AUX_NONE: assert property ((st == itm_pkg::ST_RUN && active && tick && cnt != sh[0]) |=> // R14
      (!irq[1] && tog[1] == $past(tog[1])))
      else $error("aux output changed without match");
   AST_SAME: assert property ((st == itm_pkg::ST_RUN && active && tick && cnt == sh0 && sh[0] == sh0) |=> // R12
      (irq[0] && irq[1]))
      else $error("equal compares not simultaneous");

   COV_MATCH0: cover property (st == itm_pkg::ST_RUN && tick && cnt == sh0);
   COV_WRAP: cover property (st == itm_pkg::ST_RUN && tick && cnt == itm_pkg::CNT_IDLE && sh0 != cnt);
   COV_AUX: cover property (st == itm_pkg::ST_RUN && tick && cnt == sh[2] && cnt != sh0);
endmodule

// >>> itm_far_side.sv
// Far-side model: external event source and loads on the timer pins.
// Assumes pclk-synchronous use; the bench starts the event train and never stops it.
`timescale 1ns/1ns
module itm_far_side (
   // Clock and control
   input wire logic pclk,
   input wire logic ev_run,
   input wire logic clr,
   // Timer pins seen by the loads
   input wire logic [4:0] pins,
   // Event line and toggle counts
   output logic external_event_input,
   output logic [4:0][7:0] tog
);
   logic [4:0] last = 5'h00;
   int ph = 0;

   // ----------------------------------------
   // Event train
   // ----------------------------------------
   // One rising edge every six clocks; the line parks low between trains
   initial external_event_input = 1'b0;
   always @(posedge pclk) begin
      ph <= (ph == 2) ? 0 : ph + 1;
      if (ev_run && ph == 2) begin
         external_event_input <= !external_event_input;
      end else if (!ev_run) begin
         external_event_input <= 1'b0;
      end
   end

   // ----------------------------------------
   // Pin loads
   // ----------------------------------------
   // Each level change seen at an edge is one toggle
   always @(posedge pclk) begin
      last <= pins;
      for (int i = 0; i < 5; i++) begin
         tog[i] <= clr ? 8'h00 : tog[i] + 8'(pins[i] != last[i]);
      end
   end
endmodule

// >>> interval_timer_top_bench.sv
// Self-checking bench: APB register tasks, then pulse and toggle counts
// over fixed windows. Assumes the far-side model drives the event input.
`timescale 1ns/1ns
module interval_timer_top_bench;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic external_event_input;
   logic ch0_timer_out_0;
   logic ch1_timer_out_0;
   logic ch0_compare0_match_irq;
   logic ch1_compare0_match_irq;
   logic [2:0] ch0_timer_out_aux;
   logic [2:0] ch0_compare_aux_irq;
   logic [2:0] ch1_compare_aux_irq;
   logic ev_run = 1'b0;
   logic clr = 1'b0;
   logic [7:0] irqv;
   logic [7:0][7:0] ic;
   logic [4:0][7:0] tc;
   logic [31:0] rd;
   logic err;
   int num_errors = 0;
   int checks_done = 0;

   always #5 pclk = !pclk;

   interval_timer_top uut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
      .prdata, .pready, .pslverr, .external_event_input, .ch0_timer_out_0,
      .ch0_timer_out_aux, .ch0_compare0_match_irq, .ch0_compare_aux_irq,
      .ch1_timer_out_0, .ch1_compare0_match_irq, .ch1_compare_aux_irq);

   itm_far_side far (.pclk, .ev_run, .clr, .external_event_input, .tog(tc),
      .pins({ch1_timer_out_0, ch0_timer_out_aux, ch0_timer_out_0}));

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   // Irq pulse counters, cleared together with the pin loads
   assign irqv = {ch1_compare_aux_irq, ch1_compare0_match_irq, ch0_compare_aux_irq, ch0_compare0_match_irq};
   always @(posedge pclk) begin
      for (int i = 0; i < 8; i++) begin
         ic[i] <= clr ? 8'h00 : ic[i] + 8'(irqv[i]);
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One APB transfer; waits for pready as long as it takes, the watchdog ends a hang
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      chk(pready, 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Settle, clear the counters, then count over n edges
   task automatic win(input int n);
      repeat (8) @(posedge pclk);
      clr <= 1'b1;
      @(posedge pclk);
      clr <= 1'b0;
      repeat (n) @(posedge pclk);
      #1;
   endtask

   task automatic report_and_stop;
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   // Watchdog: the sequence needs under a thousand cycles
   initial begin
      #200000;
      num_errors++;
      report_and_stop();
   end

   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, 8'h08, 0);
      chk(rd, 0);
      apb(0, 8'h18, 0);
      chk(rd, 0);
      // Unmapped, out of range and channel 1 event control are refused
      apb(1, 8'h28, 32'h1234);
      chk(err, 1);
      apb(1, 8'h80, 32'h1);
      chk(err, 1);
      apb(0, 8'h64, 0);
      chk(err, 1);
      apb(1, 8'h04, 32'hFF);
      win(2);
      chk({ch0_timer_out_aux, ch0_timer_out_0}, 32'hF);
      apb(1, 8'h04, 32'h0F);
      apb(1, 8'h08, 32'h3);
      apb(1, 8'h0C, 32'h3);
      apb(1, 8'h10, 32'h1);
      apb(1, 8'h14, 32'h5);
      apb(1, 8'h1C, 32'hFF);
      apb(1, 8'h20, 32'hFF);
      // A non-interval mode code keeps the channel idle
      apb(1, 8'h00, 32'h11);
      win(40);
      chk(ic[0] + tc[0], 0);
      apb(1, 8'h00, 32'h01);
      win(40);
      chk(ic[0], 10);
      chk(tc[0], 10);
      chk({ic[1], ic[2], ic[3]}, 24'h0A0A00);
      chk({tc[1], tc[2], tc[3]}, 24'h0A0A00);
      apb(0, 8'h18, 0);
      chk({31'h0, rd <= 32'h3}, 1);
      // Aux rewrites while running take effect without a stop
      apb(1, 8'h0C, 32'h5);
      apb(1, 8'h10, 32'h2);
      win(40);
      chk({ic[0], ic[1], ic[2]}, 24'h0A000A);
      // Channel 1 with period 0; its event clock bit does not exist
      apb(1, 8'h44, 32'h1);
      apb(1, 8'h48, 32'h0);
      apb(1, 8'h40, 32'h101);
      apb(0, 8'h40, 0);
      chk(rd, 1);
      win(40);
      chk({ic[4], tc[4]}, 16'h2828);
      chk({ic[5], ic[6], ic[7]}, 24'h282828);
      // Event clocking on channel 0 with all compares equal
      apb(1, 8'h00, 32'h0);
      apb(1, 8'h08, 32'h1);
      apb(1, 8'h0C, 32'h1);
      apb(1, 8'h10, 32'h1);
      apb(1, 8'h14, 32'h1);
      apb(1, 8'h24, 32'h1);
      apb(1, 8'h00, 32'h101);
      win(4);
      apb(0, 8'h18, 0);
      chk(rd, 32'hFFFF);
      ev_run <= 1'b1;
      for (int e = 1; e < 4; e++) begin
         apb(1, 8'h24, e);
         win(120);
         chk({ic[0], ic[1], tc[0], tc[1]}, (e == 3) ? 32'h14141414 : 32'h0A0A0A0A);
      end
      apb(1, 8'h14, 32'hFFFF);
      report_and_stop();
   end
endmodule
